// ### design/ecu_regs.vh
// Constants for the extended configuration unit: register offsets, field
// positions, reset values, mode and bias-current encodings.
// Assumes inclusion by bare name from the design files.
`ifndef ECU_REGS_VH
`define ECU_REGS_VH

// ============================================================
// Register offsets (byte addresses, one aligned word each)
`define ECU_CTRL0_OFS      8'h00
`define ECU_PIN_CTRL_OFS   8'h08
`define ECU_IRQ_STAT_OFS   8'h10
`define ECU_IRQ_MASK_OFS   8'h14

// ============================================================
// Control word 0 fields
`define ECU_LKUP_FLAG_BIT  7
`define ECU_LKUP_EN_BIT    6
`define ECU_CTRL0_RST      32'h0000_0040

// ============================================================
// Pin control half-word fields (minus pin in upper half, plus pin lower)
`define ECU_HALF_W         16
`define ECU_MINUS_BASE     16
`define ECU_F_RESULT       12
`define ECU_F_BUFCMP       11
`define ECU_F_CODE_HI      10
`define ECU_F_CODE_LO      5
`define ECU_F_PDSEL        4
`define ECU_F_PUSEL        3
`define ECU_F_BIAS_HI      2
`define ECU_F_BIAS_LO      1
`define ECU_F_DRIVE        0
`define ECU_PIN_HALF_RST   16'h0010

// ============================================================
// Interrupt status bits
`define ECU_IRQ_LKUP_BIT   0
`define ECU_IRQ_CMPM_BIT   1
`define ECU_IRQ_CMPP_BIT   2
`define ECU_IRQ_W          3

// ============================================================
// Bias current encodings
`define ECU_BIAS_PD_B      2'h1
`define ECU_BIAS_PU        2'h2
`define ECU_BIAS_PD_A      2'h3

// ============================================================
// Mode select codes, ordered {pulldown, pullup, bufcmp, drive}
`define ECU_SEL_DAC        4'hC
`define ECU_SEL_DACBUF     4'hF
`define ECU_SEL_CMP        4'hE
`define ECU_SEL_PULLUP     4'h4
`define ECU_SEL_PULLDN     4'h8

// ============================================================
// One-hot analog modes
`define ECU_MODE_W         6
`define ECU_MODE_OFF       6'h01
`define ECU_MODE_DAC       6'h02
`define ECU_MODE_DACBUF    6'h04
`define ECU_MODE_CMP       6'h08
`define ECU_MODE_PULLUP    6'h10
`define ECU_MODE_PULLDN    6'h20

`endif

// ### design/ecu_pin_ctrl.v
// One charger-detection pin: mode decode, bias decode and comparator sync.
// Assumes the comparator result arrives asynchronously from the analog side.
`timescale 1ns/100ps
`default_nettype none
`include "ecu_regs.vh"

module ecu_pin_ctrl (
  input  wire        core_clk,       // System bus clock
  input  wire        resetn,         // Async active-low system reset
  input  wire        pd_sel,         // Pull-down select bit
  input  wire        pu_sel,         // Pull-up select bit
  input  wire        bufcmp_en,      // Buffer/comparator enable bit
  input  wire        drive_en,       // Buffer drive enable bit
  input  wire [1:0]  bias_sel,       // Bias current select
  input  wire        cmp_async,      // Raw comparator output
  output reg  [5:0]  mode,           // One-hot analog mode
  output reg         wpu_en,         // Weak pull-up current
  output reg         wpd_a_en,       // Weak pull-down current a
  output reg         wpd_b_en,       // Weak pull-down current b
  output reg         cmp_sync,       // Synchronised comparator result
  output wire        cmp_change      // One-cycle pulse on result change
);

  // ============================================================
  // Synchroniser: three stages, a change counts when stages two and three agree
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s1_reg   <= 1'b0;
      s2_reg   <= 1'b0;
      s3_reg   <= 1'b0;
      cmp_sync <= 1'b0;
    end else begin
      s1_reg <= cmp_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        cmp_sync <= s3_reg; // RL17
      end
    end
  end
  assign cmp_change = (s2_reg == s3_reg) && (s3_reg != cmp_sync);

  // ============================================================
  // Mode decode; combinations not listed leave the analog path off
  reg [5:0] mode_next;
  always @* begin
    case ({pd_sel, pu_sel, bufcmp_en, drive_en})
      `ECU_SEL_DAC:    mode_next = `ECU_MODE_DAC;    // RL6
      `ECU_SEL_DACBUF: mode_next = `ECU_MODE_DACBUF; // RL7
      `ECU_SEL_CMP:    mode_next = `ECU_MODE_CMP;    // RL8 RL9
      `ECU_SEL_PULLUP: mode_next = `ECU_MODE_PULLUP; // RL10
      `ECU_SEL_PULLDN: mode_next = `ECU_MODE_PULLDN; // RL11
      default: mode_next = `ECU_MODE_OFF;    // RL15
    endcase
  end

  // Registered so analog controls never glitch during a write
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      // Reset control selects pull-down, so the pin must not float in reset
      mode     <= `ECU_MODE_PULLDN; // RL11
      wpu_en   <= 1'b0;
      wpd_a_en <= 1'b0;
      wpd_b_en <= 1'b0;
    end else begin
      mode     <= mode_next;
      wpu_en   <= (bias_sel == `ECU_BIAS_PU);   // RL12
      wpd_a_en <= (bias_sel == `ECU_BIAS_PD_A); // RL13
      wpd_b_en <= (bias_sel == `ECU_BIAS_PD_B); // RL14
    end
  end

endmodule // ecu_pin_ctrl
`default_nettype wire

// ### design/ecu_top.v
// Extended configuration unit: lock-up monitor and charger-pin mode control.
// Assumes a single-cycle strobe register port on the system bus clock and
// that resetn is the full system reset only, not the lock-up reset.
//
// Summary of operation
// RL1 - Runs on bus clock; only system reset clears
// RL2 - Enable bit gates lock-up watching
// RL3 - Lock-up requests reset, sets surviving flag
// RL4 - Writing one clears flag; zero keeps
// RL5 - Six-bit code per pin, voltage and resistor
// RL6 - 1100 selects unbuffered DAC mode
// RL7 - 1111 selects buffered DAC mode
// RL8 - 1110 selects comparator mode
// RL9 - Comparator result delivered to logic
// RL10 - 0100 selects programmable pull-up mode
// RL11 - 1000 selects programmable pull-down mode
// RL12 - Bias 10 enables weak pull-up current
// RL13 - Bias 11 enables weak pull-down a
// RL14 - Bias 01 enables weak pull-down b
// RL15 - Both selects zero disables DAC, pulls
// RL16 - Monitor enable resets to one, RW
// RL17 - Comparator result synchronised before reading
// RL18 - Each pin has independent identical controls
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "ecu_regs.vh"

module ecu_top (
  input  wire        core_clk,        // System bus clock
  input  wire        resetn,          // Async active-low system reset
  input  wire [7:0]  reg_addr,        // Register byte address
  input  wire [31:0] reg_wdata,       // Write data
  input  wire        reg_wr,          // Write strobe
  input  wire        reg_rd,          // Read strobe
  output reg  [31:0] reg_rdata,       // Read data, cycle after strobe
  input  wire        cpu_lockup,      // Processor lock-up level
  output reg         sw_reset_req,    // One-cycle system reset request
  output wire        irq,             // Level interrupt
  output wire [5:0]  minus_dac_code,  // Minus pin DAC code
  output wire [5:0]  minus_mode,      // Minus pin one-hot mode
  output wire        minus_wpu_en,    // Minus pin weak pull-up current
  output wire        minus_wpd_a_en,  // Minus pin weak pull-down a
  output wire        minus_wpd_b_en,  // Minus pin weak pull-down b
  input  wire        minus_cmp_in,    // Minus pin raw comparator
  output wire [5:0]  plus_dac_code,   // Plus pin DAC code
  output wire [5:0]  plus_mode,       // Plus pin one-hot mode
  output wire        plus_wpu_en,     // Plus pin weak pull-up current
  output wire        plus_wpd_a_en,   // Plus pin weak pull-down a
  output wire        plus_wpd_b_en,   // Plus pin weak pull-down b
  input  wire        plus_cmp_in      // Plus pin raw comparator
);

  // ============================================================
  // Register decode
  wire wr_ctrl0 = reg_wr && (reg_addr == `ECU_CTRL0_OFS);
  wire wr_pin   = reg_wr && (reg_addr == `ECU_PIN_CTRL_OFS);
  wire wr_stat  = reg_wr && (reg_addr == `ECU_IRQ_STAT_OFS);
  wire wr_mask  = reg_wr && (reg_addr == `ECU_IRQ_MASK_OFS);

  // ============================================================
  // Control state; only the system reset returns it to defaults
  reg                   lkup_en_reg;
  reg                   lkup_flag_reg;
  reg [`ECU_HALF_W-1:0] minus_ctl_reg;
  reg [`ECU_HALF_W-1:0] plus_ctl_reg;
  reg [`ECU_IRQ_W-1:0]  irq_stat_reg;
  reg [`ECU_IRQ_W-1:0]  irq_mask_reg;
  reg                   lkup_d_reg;

  // Lock-up edge detect so a held lock-up requests one reset only
  wire lkup_event = cpu_lockup && !lkup_d_reg && lkup_en_reg; // RL2

  wire       minus_cmp;
  wire       plus_cmp;
  wire       minus_chg;
  wire       plus_chg;

  wire [`ECU_IRQ_W-1:0] irq_events = {plus_chg, minus_chg, lkup_event};

  always @(posedge core_clk or negedge resetn) begin // RL1
    if (!resetn) begin
      lkup_en_reg   <= 1'b1; // RL16
      lkup_flag_reg <= 1'b0;
      lkup_d_reg    <= 1'b0;
      sw_reset_req  <= 1'b0;
      minus_ctl_reg <= `ECU_PIN_HALF_RST;
      plus_ctl_reg  <= `ECU_PIN_HALF_RST;
      irq_stat_reg  <= {`ECU_IRQ_W{1'b0}};
      irq_mask_reg  <= {`ECU_IRQ_W{1'b0}};
    end else begin
      lkup_d_reg   <= cpu_lockup;
      sw_reset_req <= lkup_event; // RL3
      if (wr_ctrl0) begin
        lkup_en_reg <= reg_wdata[`ECU_LKUP_EN_BIT]; // RL16
      end
      // Set wins over a same-cycle clear
      if (lkup_event) begin
        lkup_flag_reg <= 1'b1; // RL3
      end else if (wr_ctrl0 && reg_wdata[`ECU_LKUP_FLAG_BIT]) begin
        lkup_flag_reg <= 1'b0; // RL4
      end
      if (wr_pin) begin
        minus_ctl_reg <= reg_wdata[`ECU_MINUS_BASE +: `ECU_HALF_W]; // RL18
        plus_ctl_reg  <= reg_wdata[0 +: `ECU_HALF_W];
      end
      if (wr_mask) begin
        irq_mask_reg <= reg_wdata[`ECU_IRQ_W-1:0];
      end
      irq_stat_reg <= (irq_stat_reg & ~(wr_stat ? reg_wdata[`ECU_IRQ_W-1:0] : {`ECU_IRQ_W{1'b0}}))
                      | irq_events;
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ============================================================
  // Per-pin decode, one instance each
  assign minus_dac_code = minus_ctl_reg[`ECU_F_CODE_HI:`ECU_F_CODE_LO]; // RL5
  assign plus_dac_code  = plus_ctl_reg[`ECU_F_CODE_HI:`ECU_F_CODE_LO];  // RL5

  ecu_pin_ctrl u_minus (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .pd_sel     (minus_ctl_reg[`ECU_F_PDSEL]),
    .pu_sel     (minus_ctl_reg[`ECU_F_PUSEL]),
    .bufcmp_en  (minus_ctl_reg[`ECU_F_BUFCMP]),
    .drive_en   (minus_ctl_reg[`ECU_F_DRIVE]),
    .bias_sel   (minus_ctl_reg[`ECU_F_BIAS_HI:`ECU_F_BIAS_LO]),
    .cmp_async  (minus_cmp_in),
    .mode       (minus_mode),
    .wpu_en     (minus_wpu_en),
    .wpd_a_en   (minus_wpd_a_en),
    .wpd_b_en   (minus_wpd_b_en),
    .cmp_sync   (minus_cmp),
    .cmp_change (minus_chg)
  );

  ecu_pin_ctrl u_plus (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .pd_sel     (plus_ctl_reg[`ECU_F_PDSEL]),
    .pu_sel     (plus_ctl_reg[`ECU_F_PUSEL]),
    .bufcmp_en  (plus_ctl_reg[`ECU_F_BUFCMP]),
    .drive_en   (plus_ctl_reg[`ECU_F_DRIVE]),
    .bias_sel   (plus_ctl_reg[`ECU_F_BIAS_HI:`ECU_F_BIAS_LO]),
    .cmp_async  (plus_cmp_in),
    .mode       (plus_mode),
    .wpu_en     (plus_wpu_en),
    .wpd_a_en   (plus_wpd_a_en),
    .wpd_b_en   (plus_wpd_b_en),
    .cmp_sync   (plus_cmp),
    .cmp_change (plus_chg)
  );

  // ============================================================
  // Read path: result bits replace the stored bit 12 of each half
  reg [`ECU_HALF_W-1:0] minus_rd;
  reg [`ECU_HALF_W-1:0] plus_rd;
  always @* begin
    minus_rd = minus_ctl_reg;
    plus_rd  = plus_ctl_reg;
    minus_rd[`ECU_HALF_W-1:`ECU_F_RESULT] = 4'h0;
    plus_rd[`ECU_HALF_W-1:`ECU_F_RESULT]  = 4'h0;
    minus_rd[`ECU_F_RESULT] = minus_cmp; // RL9 RL17
    plus_rd[`ECU_F_RESULT]  = plus_cmp;
  end

  // Unmapped addresses read as zero
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `ECU_CTRL0_OFS: begin
          reg_rdata <= 32'h0000_0000;
          reg_rdata[`ECU_LKUP_FLAG_BIT] <= lkup_flag_reg;
          reg_rdata[`ECU_LKUP_EN_BIT]   <= lkup_en_reg;
        end
        `ECU_PIN_CTRL_OFS: reg_rdata <= {minus_rd, plus_rd};
        `ECU_IRQ_STAT_OFS: reg_rdata <= {29'h0000_0000, irq_stat_reg};
        `ECU_IRQ_MASK_OFS: reg_rdata <= {29'h0000_0000, irq_mask_reg};
        default:           reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule // ecu_top
`default_nettype wire

// ### tb/ecu_top_sva.sv
// Checker for the extended configuration unit, top ports only.
// Assumes one bus clock and the async active-low system reset.
`timescale 1ns/100ps
`default_nettype none
module ecu_top_sva (
  input wire logic        core_clk,       // Bus clock
  input wire logic        resetn,         // System reset
  input wire logic [7:0]  reg_addr,       // Address
  input wire logic [31:0] reg_wdata,      // Write data
  input wire logic        reg_wr,         // Write strobe
  input wire logic        reg_rd,         // Read strobe
  input wire logic [31:0] reg_rdata,      // Read data
  input wire logic        cpu_lockup,     // Lock-up level
  input wire logic        sw_reset_req,   // Reset request
  input wire logic [5:0]  minus_dac_code, // Minus code
  input wire logic [5:0]  plus_dac_code,  // Plus code
  input wire logic [5:0]  plus_mode,      // Plus mode
  input wire logic        plus_wpu_en     // Plus weak pull-up
);
  // ====
  // Shadow of the monitor enable, since it is not visible at the ports
  logic en_reg; // Monitor enable copy
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn)
      en_reg <= 1'b1;
    else if (reg_wr && reg_addr == 8'h00)
      en_reg <= reg_wdata[6];
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // ====
  // Lock-up request
  property p_req_on; $rose(cpu_lockup) && en_reg |=> sw_reset_req; endproperty
  a_req_on: assert property (p_req_on) else $error("missing reset request");
  property p_req_cause; sw_reset_req |-> $past(en_reg) && $past(cpu_lockup) && !$past(cpu_lockup, 2); endproperty
  a_req_cause: assert property (p_req_cause) else $error("reset request without cause");
  property p_req_pulse; sw_reset_req |=> !sw_reset_req; endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("reset request too long");
  property p_ctrl_rsvd; reg_rd && reg_addr == 8'h00 |=> reg_rdata[31:8] == 24'h0 && reg_rdata[5:0] == 6'h0; endproperty
  a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("control reserved bits set");
  // ====
  // Pin control decode, two cycles after a lone write
  sequence s_pin; reg_wr && reg_addr == 8'h08 ##1 !(reg_wr && reg_addr == 8'h08); endsequence
  property p_code; s_pin |=> minus_dac_code == $past(reg_wdata[26:21], 2) && plus_dac_code == $past(reg_wdata[10:5], 2);
  endproperty
  a_code: assert property (p_code) else $error("pin code mismatch");
  property p_off; (reg_wdata[4:3] == 2'h0) ##0 s_pin |=> plus_mode == 6'h01; endproperty
  a_off: assert property (p_off) else $error("pin not off");
  property p_dac; (reg_wdata[11] == 1'b0 && reg_wdata[4:3] == 2'h3 && reg_wdata[0] == 1'b0) ##0 s_pin |=> plus_mode == 6'h02;
  endproperty
  a_dac: assert property (p_dac) else $error("pin not in plain DAC mode");
  property p_bias; s_pin |=> plus_wpu_en == ($past(reg_wdata[2:1], 2) == 2'h2); endproperty
  a_bias: assert property (p_bias) else $error("weak pull-up mismatch");
  c_req: cover property (sw_reset_req);
  c_cmp: cover property (plus_mode == 6'h08);
  c_up: cover property (plus_wpu_en);
endmodule // ecu_top_sva
`default_nettype wire

// ### tb/ecu_top_test.sv
// Self-checking bench for the extended configuration unit.
// Assumes the header constants; the bench drives every port itself.
`timescale 1ns/100ps
`default_nettype none
`include "ecu_regs.vh"
module ecu_top_test;
  logic        core_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, cpu_lockup = 1'b0;
  logic        m_cmp = 1'b0, p_cmp = 1'b0, sw_reset_req, irq, m_pu, m_pa, m_pb, p_pu, p_pa, p_pb;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, pin_m;
  logic [5:0]  m_code, m_mode, p_code, p_mode;
  integer      errors = 0, checks = 0, seed = 32'hEB293DC6, i, n;
  ecu_top ecu_top_i (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_lockup(cpu_lockup), .sw_reset_req(sw_reset_req),
    .irq(irq), .minus_dac_code(m_code), .minus_mode(m_mode), .minus_wpu_en(m_pu), .minus_wpd_a_en(m_pa),
    .minus_wpd_b_en(m_pb), .minus_cmp_in(m_cmp), .plus_dac_code(p_code), .plus_mode(p_mode), .plus_wpu_en(p_pu),
    .plus_wpd_a_en(p_pa), .plus_wpd_b_en(p_pb), .plus_cmp_in(p_cmp));
  // Free-running bus clock
  always #5 core_clk = ~core_clk;
  // ====
  // Compare, bus and model tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", exp, reg_rdata);
  endtask
  // A held lock-up must give exactly exp requests: one with the monitor enabled, none with it disabled
  task automatic lock(input integer exp);
    @(posedge core_clk) cpu_lockup <= 1'b1;
    n = 0;
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge core_clk);
      #1 n = n + (sw_reset_req === 1'b1);
    end
    @(posedge core_clk) cpu_lockup <= 1'b0;
    chk("req_count", exp, n);
  endtask
  function automatic logic [15:0] half(input logic [3:0] s, input logic [1:0] b, input logic [5:0] c);
    half = {4'h1, s[1], c, s[3], s[2], b, s[0]};
  endfunction
  function automatic logic [5:0] mode_of(input logic [3:0] s);
    case (s)
      4'hC: mode_of = `ECU_MODE_DAC;
      4'hF: mode_of = `ECU_MODE_DACBUF;
      4'hE: mode_of = `ECU_MODE_CMP;
      4'h4: mode_of = `ECU_MODE_PULLUP;
      4'h8: mode_of = `ECU_MODE_PULLDN;
      default: mode_of = `ECU_MODE_OFF;
    endcase
  endfunction
  task automatic pin_chk(input logic [15:0] h, input logic [5:0] md, input logic [5:0] cd, input logic [2:0] cur);
    chk("mode", {26'h0, mode_of({h[4], h[3], h[11], h[0]})}, {26'h0, md});
    chk("code", {26'h0, h[10:5]}, {26'h0, cd});
    chk("bias", {29'h0, h[2:1] == 2'h2, h[2:1] == 2'h3, h[2:1] == 2'h1}, {29'h0, cur});
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Watchdog against a hung run
  initial begin
    #200000;
    errors = errors + 1;
    complete_run;
  end
  // ====
  // Main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    #1 chk("mode", {20'h0, mode_of(4'h8), mode_of(4'h8)}, {20'h0, m_mode, p_mode});
    rc(8'h00, 32'h40);
    rc(8'h08, 32'h00100010);
    rc(8'h0C, 32'h0);
    $display("test reset values done");
    lock(1);
    rc(8'h00, 32'hC0);
    rc(8'h10, 32'h1);
    chk("irq", 0, {31'h0, irq});
    wr(8'h14, 32'h1);
    #1 chk("irq", 1, {31'h0, irq});
    wr(8'h00, 32'h40);
    rc(8'h00, 32'hC0);
    wr(8'h00, 32'hC0);
    rc(8'h00, 32'h40);
    wr(8'h10, 32'h1);
    #1 chk("irq", 0, {31'h0, irq});
    wr(8'h00, 32'h0);
    lock(0);
    rc(8'h00, 32'h0);
    wr(8'h00, 32'h40);
    $display("test lock-up done");
    for (int k = 0; k < 16; k = k + 1) begin
      n = $random(seed);
      pin_m = {half(~k[3:0], k[3:2], n[5:0]), half(k[3:0], k[1:0], n[11:6])};
      wr(8'h08, pin_m);
      @(posedge core_clk);
      #1 pin_chk(pin_m[31:16], m_mode, m_code, {m_pu, m_pa, m_pb});
      pin_chk(pin_m[15:0], p_mode, p_code, {p_pu, p_pa, p_pb});
      rc(8'h08, pin_m & 32'h0FFF0FFF);
    end
    $display("test pin modes done");
    wr(8'h14, 32'h6);
    @(posedge core_clk);
    p_cmp <= 1'b1;
    m_cmp <= 1'b1;
    repeat (6) @(posedge core_clk);
    rc(8'h08, (pin_m & 32'h0FFF0FFF) | 32'h10001000);
    rc(8'h10, 32'h6);
    chk("irq", 1, {31'h0, irq});
    wr(8'h10, 32'h6);
    #1 chk("irq", 0, {31'h0, irq});
    $display("test comparator done");
    lock(1);
    @(posedge core_clk) resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    #1 chk("mode", {20'h0, mode_of(4'h8), mode_of(4'h8)}, {20'h0, m_mode, p_mode});
    rc(8'h00, 32'h40);
    rc(8'h14, 32'h0);
    $display("test second reset done");
    complete_run;
  end
endmodule // ecu_top_test
bind ecu_top ecu_top_sva ecu_top_sva_i (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_lockup(cpu_lockup),
  .sw_reset_req(sw_reset_req), .minus_dac_code(minus_dac_code), .plus_dac_code(plus_dac_code),
  .plus_mode(plus_mode), .plus_wpu_en(plus_wpu_en));
`default_nettype wire
